// [hw/fifo_status_flags.sv]
// dual-clock fifo with full, empty and programmable almost flags
module fifo_status_flags
	import fifo_flags_pkg::*;
#(
	parameter int DEPTH = DEPTH_DEF
) (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	// write port
	input wire logic i_wr_clk,
	input wire logic i_wr_enable_one_n,
	input wire logic i_wr_enable_two_or_load,
	input wire logic [DATA_W-1:0] i_write_word_in,
	// read port
	input wire logic i_rd_clk,
	input wire logic i_rd_enable_one_n,
	input wire logic i_rd_enable_two_n,
	input wire logic i_output_enable_n,
	output logic [DATA_W-1:0] o_read_word_out,
	output logic o_read_word_oe,
	// status
	output flags_t o_flags
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] DEPTH_P = (AW+1)'(DEPTH);

	if (DEPTH < DEPTH_MIN || DEPTH > DEPTH_MAX || (1 << AW) != DEPTH) begin : g_depth_check
		$error("DEPTH must be a power of two from 64 to 8192");
	end

	function automatic logic [AW:0] to_gray(input logic [AW:0] b);
		return b ^ (b >> 1);
	endfunction

	function automatic logic [AW:0] from_gray(input logic [AW:0] g);
		logic [AW:0] b;
		b[AW] = g[AW];
		for (int i = AW - 1; i >= 0; i--) begin
			b[i] = b[i+1] ^ g[i];
		end
		return b;
	endfunction

	logic [DATA_W-1:0] mem [DEPTH];
	logic wclk_q_ff, rclk_q_ff;
	logic dual_en_ff;
	logic [AW:0] wptr_ff, rptr_ff, wgray_ff, rgray_ff;
	logic [AW:0] wsync_ff [SYNC_STAGES];
	logic [AW:0] rsync_ff [SYNC_STAGES];
	logic [OFS_W-1:0] ofs_ff [4];
	ofs_sel_t wsel_ff, rsel_ff;
	logic wr_edge, rd_edge, load_mode, wr_go, ld_go, rd_en, rd_go, ofs_rd;
	logic [AW:0] nxt_wptr, nxt_rptr, wcount, rcount, rsync_bin, wsync_bin;
	logic [15:0] full_ofs, empty_ofs;
	// one flop per flag so each clock domain owns its own variables
	logic full_n_ff, afull_n_ff, aempty_n_ff, empty_n_ff;

	// pin clocks arrive synchronous to the reference clock, so edges are plain compares
	always_ff @(posedge i_ref_clk) begin
		wclk_q_ff <= i_wr_clk;
		rclk_q_ff <= i_rd_clk;
	end
	assign wr_edge = i_wr_clk & ~wclk_q_ff;
	assign rd_edge = i_rd_clk & ~rclk_q_ff;

	// mode strap caught every cycle while reset is held, free-running clocks are harmless
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n)
			dual_en_ff <= i_wr_enable_two_or_load;
	end

	assign load_mode = ~dual_en_ff & ~i_wr_enable_two_or_load;
	assign wr_go = wr_edge & ~i_wr_enable_one_n & i_wr_enable_two_or_load & o_flags.full_n;
	assign ld_go = wr_edge & ~i_wr_enable_one_n & load_mode;
	assign rd_en = ~i_rd_enable_one_n & ~i_rd_enable_two_n;
	assign ofs_rd = rd_edge & rd_en & load_mode;
	assign rd_go = rd_edge & rd_en & ~load_mode & o_flags.empty_n;
	assign nxt_wptr = wr_go ? wptr_ff + 1'b1 : wptr_ff;
	assign nxt_rptr = rd_go ? rptr_ff + 1'b1 : rptr_ff;
	assign full_ofs = {ofs_ff[3], ofs_ff[2]};
	assign empty_ofs = {ofs_ff[1], ofs_ff[0]};

	// storage array
	always_ff @(posedge i_ref_clk) begin
		if (wr_go)
			mem[wptr_ff[AW-1:0]] <= i_write_word_in;
	end

	// write pointer and its gray copy
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			wptr_ff <= '0;
			wgray_ff <= '0;
		end else begin
			wptr_ff <= nxt_wptr;
			wgray_ff <= to_gray(nxt_wptr);
		end
	end

	// read pointer and its gray copy
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			rptr_ff <= '0;
			rgray_ff <= '0;
		end else begin
			rptr_ff <= nxt_rptr;
			rgray_ff <= to_gray(nxt_rptr);
		end
	end

	// each pointer is resampled on the far port's own edges; costs flag latency, never a false count
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			for (int i = 0; i < SYNC_STAGES; i++) begin
				wsync_ff[i] <= '0;
				rsync_ff[i] <= '0;
			end
		end else begin
			if (rd_edge) begin
				wsync_ff[0] <= wgray_ff;
				wsync_ff[1] <= wsync_ff[0];
			end
			if (wr_edge) begin
				rsync_ff[0] <= rgray_ff;
				rsync_ff[1] <= rsync_ff[0];
			end
		end
	end
	assign rsync_bin = from_gray(rsync_ff[SYNC_STAGES-1]);
	assign wsync_bin = from_gray(wsync_ff[SYNC_STAGES-1]);
	assign wcount = nxt_wptr - rsync_bin;
	assign rcount = wsync_bin - nxt_rptr;

	// offset registers, loaded one byte per write edge in a wrapping order
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			ofs_ff[0] <= OFS_DEF[7:0];
			ofs_ff[1] <= OFS_DEF[15:8];
			ofs_ff[2] <= OFS_DEF[7:0];
			ofs_ff[3] <= OFS_DEF[15:8];
			wsel_ff <= SEL_EMPTY_LO;
		end else if (ld_go) begin
			ofs_ff[wsel_ff] <= i_write_word_in[OFS_W-1:0];
			case (wsel_ff)
				SEL_EMPTY_LO: wsel_ff <= SEL_EMPTY_HI;
				SEL_EMPTY_HI: wsel_ff <= SEL_FULL_LO;
				SEL_FULL_LO: wsel_ff <= SEL_FULL_HI;
				default: wsel_ff <= SEL_EMPTY_LO;
			endcase
		end
	end

	// write-side flags, only on write clock edges
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			full_n_ff <= 1'b1;
			afull_n_ff <= 1'b1;
		end else if (wr_edge) begin
			full_n_ff <= ~(wcount == DEPTH_P);
			afull_n_ff <= ~({3'h0, wcount} + {3'h0, full_ofs[AW:0]} >= {3'h0, DEPTH_P});
		end
	end

	// read-side flags, only on read clock edges
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			empty_n_ff <= 1'b0;
			aempty_n_ff <= 1'b0;
		end else if (rd_edge) begin
			empty_n_ff <= ~(wsync_bin == nxt_rptr);
			aempty_n_ff <= ~(rcount <= empty_ofs[AW:0]);
		end
	end
	assign o_flags = '{full_n: full_n_ff, almost_full_n: afull_n_ff, almost_empty_n: aempty_n_ff, empty_n: empty_n_ff};

	// output register and offset readback walk
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			o_read_word_out <= '0;
			rsel_ff <= SEL_EMPTY_LO;
		end else if (rd_go) begin
			o_read_word_out <= mem[rptr_ff[AW-1:0]];
		end else if (ofs_rd) begin
			o_read_word_out <= {1'b0, ofs_ff[rsel_ff]};
			case (rsel_ff)
				SEL_EMPTY_LO: rsel_ff <= SEL_EMPTY_HI;
				SEL_EMPTY_HI: rsel_ff <= SEL_FULL_LO;
				SEL_FULL_LO: rsel_ff <= SEL_FULL_HI;
				default: rsel_ff <= SEL_EMPTY_LO;
			endcase
		end
	end

	// output enable pin is registered so the drive flag comes from a flop
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n)
			o_read_word_oe <= 1'b0;
		else
			o_read_word_oe <= ~i_output_enable_n;
	end

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);

	sequence wr_try_s;
		wr_edge && !i_wr_enable_one_n && i_wr_enable_two_or_load;
	endsequence
	sequence rd_try_s;
		rd_edge && rd_en && !load_mode;
	endsequence

	full_blocks_write_a: assert property (wr_try_s ##0 !o_flags.full_n |=> $stable(wptr_ff))
		else $error("write accepted while full");
	empty_blocks_read_a: assert property (rd_try_s ##0 !o_flags.empty_n |=> $stable(rptr_ff))
		else $error("read accepted while empty");
	write_advances_a: assert property (wr_try_s ##0 o_flags.full_n |=> wptr_ff == $past(wptr_ff) + 1'b1)
		else $error("valid write did not advance pointer");
	full_on_wedge_a: assert property ($changed(o_flags.full_n) || $changed(o_flags.almost_full_n) |-> $past(wr_edge))
		else $error("write flag moved off a write edge");
	empty_on_redge_a: assert property ($changed(o_flags.empty_n) || $changed(o_flags.almost_empty_n) |-> $past(rd_edge))
		else $error("read flag moved off a read edge");
	dual_enable_block_a: assert property (dual_en_ff && wr_edge && !i_wr_enable_two_or_load |=> $stable(wptr_ff))
		else $error("write taken with second enable inactive");
	dual_keeps_default_a: assert property (dual_en_ff |-> full_ofs == OFS_DEF && empty_ofs == OFS_DEF)
		else $error("offsets moved in second-enable mode");
	reset_state_a: assert property ($past(!i_rst_n) |-> o_flags == 4'b1100 && o_read_word_out == '0 && wptr_ff == '0)
		else $error("reset state wrong");
	full_implies_af_a: assert property (!o_flags.full_n |-> !o_flags.almost_full_n)
		else $error("full without almost full");
	empty_implies_ae_a: assert property (!o_flags.empty_n |-> !o_flags.almost_empty_n)
		else $error("empty without almost empty");
endmodule

// [shared/fifo_flags_pkg.sv]
// constants and types for the dual-clock fifo status-flag block
package fifo_flags_pkg;
	localparam int DATA_W = 9;
	localparam int DEPTH_DEF = 64;
	localparam int DEPTH_MIN = 64;
	localparam int DEPTH_MAX = 8192;
	localparam int OFS_W = 8;
	localparam logic [15:0] OFS_DEF = 16'h0007;
	localparam int SYNC_STAGES = 2;

	typedef enum logic [1:0] {
		SEL_EMPTY_LO,
		SEL_EMPTY_HI,
		SEL_FULL_LO,
		SEL_FULL_HI
	} ofs_sel_t;

	typedef struct packed {
		logic full_n;
		logic almost_full_n;
		logic almost_empty_n;
		logic empty_n;
	} flags_t;
endpackage

// [test/port_agent.sv]
// writer and reader logic on the far side of the fifo ports
module port_agent
	import fifo_flags_pkg::*;
(
	// ref clock
	input wire logic i_ref_clk,
	// write side
	output logic o_wr_clk,
	output logic o_wr_enable_one_n,
	output logic o_wr_enable_two_or_load,
	output logic [DATA_W-1:0] o_write_word_in,
	// read side
	output logic o_rd_clk,
	output logic o_rd_enable_one_n,
	output logic o_rd_enable_two_n
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		{o_wr_clk, o_rd_clk} = 2'b00;
		{o_wr_enable_one_n, o_wr_enable_two_or_load, o_rd_enable_one_n, o_rd_enable_two_n} = 4'hf;
		o_write_word_in = '0;
	end
	// one port clock period: low half, high half, held over the sampling edge
	task automatic cyc(input logic w, r, we, t, r1, r2, input logic [DATA_W-1:0] d);
		@(negedge i_ref_clk);
		o_wr_clk = 1'b0;
		o_rd_clk = 1'b0;
		o_wr_enable_one_n = we;
		o_wr_enable_two_or_load = t;
		o_rd_enable_one_n = r1;
		o_rd_enable_two_n = r2;
		// idle data is scrambled so a stale word cannot pass as valid
		o_write_word_in = we ? ~o_write_word_in : d;
		@(negedge i_ref_clk);
		o_wr_clk = w;
		o_rd_clk = r;
		@(posedge i_ref_clk);
		#1;
	endtask
endmodule

// [test/testbench.sv]
// self-checking bench for the dual-clock fifo flags
`define CHK(a,b) begin n_tests++; if ((a) !== (b)) begin failures++; $display("ERROR %0t got %h exp %h", $time, a, b); end end
module testbench
	import fifo_flags_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int DEPTH = 64;
	logic i_ref_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic i_output_enable_n = 1'b0;
	logic wclk, rclk, we1, wt, re1, re2, oe;
	logic [DATA_W-1:0] wd, q, last, q2;
	flags_t fl, fl2;
	int failures = 0;
	int n_tests = 0;
	logic [15:0] r = 16'h0008;
	logic [DATA_W-1:0] exp_q[$];
	logic [DATA_W-1:0] ofs [5] = '{9'h003, 9'h000, 9'h005, 9'h000, 9'h003};
	initial forever #25 i_ref_clk = ~i_ref_clk;
	port_agent u_port_agent (.i_ref_clk(i_ref_clk), .o_wr_clk(wclk), .o_wr_enable_one_n(we1),
		.o_wr_enable_two_or_load(wt), .o_write_word_in(wd), .o_rd_clk(rclk), .o_rd_enable_one_n(re1),
		.o_rd_enable_two_n(re2));
	fifo_status_flags #(.DEPTH(DEPTH)) u_fifo_status_flags (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
		.i_wr_clk(wclk), .i_wr_enable_one_n(we1), .i_wr_enable_two_or_load(wt), .i_write_word_in(wd),
		.i_rd_clk(rclk), .i_rd_enable_one_n(re1), .i_rd_enable_two_n(re2),
		.i_output_enable_n(i_output_enable_n), .o_read_word_out(q), .o_read_word_oe(oe), .o_flags(fl));
	// second device paralleled for width: same controls, fed the complement of the same write word
	fifo_status_flags #(.DEPTH(DEPTH)) u_fifo_status_flags_hi (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
		.i_wr_clk(wclk), .i_wr_enable_one_n(we1), .i_wr_enable_two_or_load(wt), .i_write_word_in(~wd),
		.i_rd_clk(rclk), .i_rd_enable_one_n(re1), .i_rd_enable_two_n(re2),
		.i_output_enable_n(i_output_enable_n), .o_read_word_out(q2), .o_read_word_oe(), .o_flags(fl2));
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic wr(input logic [DATA_W-1:0] d);
		u_port_agent.cyc(1, 0, 0, 1, 1, 1, d);
	endtask
	task automatic rd(input logic e2);
		u_port_agent.cyc(0, 1, 1, 1, 0, e2, '0);
	endtask
	// flags cross domains in three edges of the receiving port, so three idle periods settle them
	task automatic idle3;
		repeat (3) u_port_agent.cyc(1, 1, 1, 1, 1, 1, '0);
	endtask
	task automatic rst(input logic strap);
		@(negedge i_ref_clk);
		i_rst_n = 1'b0;
		repeat (5) u_port_agent.cyc(1, 1, 1, strap, 1, 1, '0);
		`CHK(fl, 4'b1100)
		`CHK(q, 9'h000)
		`CHK(oe, 1'b0)
		@(negedge i_ref_clk);
		i_rst_n = 1'b1;
		last = '0;
	endtask
	task automatic run(input int m, input int n);
		logic [DATA_W-1:0] e;
		for (int k = 1; k <= DEPTH; k++) begin
			r = lfsr(r);
			wr(r[8:0]);
			exp_q.push_back(r[8:0]);
			`CHK(fl.almost_full_n, 1'(k < DEPTH - m))
			`CHK(fl.full_n, 1'(k < DEPTH))
			`CHK(fl.full_n & fl2.full_n, 1'(k < DEPTH))
		end
		wr(9'h1aa);
		`CHK(fl.full_n, 1'b0)
		idle3();
		`CHK(fl.empty_n, 1'b1)
		`CHK(fl.almost_empty_n, 1'b1)
		for (int k = DEPTH - 1; k >= 0; k--) begin
			r = lfsr(r);
			if (r[0]) begin
				rd(1'b1);
				`CHK(q, last)
			end
			rd(1'b0);
			e = exp_q.pop_front();
			last = e;
			`CHK(q, e)
			`CHK(q2, ~e)
			`CHK(fl.empty_n & fl2.empty_n, 1'(k > 0))
			`CHK(fl.almost_empty_n, 1'(k > n))
			`CHK(fl.empty_n, 1'(k > 0))
		end
		rd(1'b0);
		`CHK(q, last)
		idle3();
		`CHK(fl.full_n, 1'b1)
		`CHK(fl.almost_full_n, 1'b1)
		$display("run done m=%0d n=%0d", m, n);
	endtask
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (100000) @(posedge i_ref_clk);
		failures++;
		report_and_stop();
	end
	initial begin
		rst(1'b0);
		@(negedge i_ref_clk);
		`CHK(oe, 1'b1)
		i_output_enable_n = 1'b1;
		repeat (2) @(negedge i_ref_clk);
		`CHK(oe, 1'b0)
		i_output_enable_n = 1'b0;
		$display("output enable test done");
		run(7, 7);
		for (int i = 0; i < 5; i++) u_port_agent.cyc(1, 0, 0, 0, 1, 1, ofs[i]);
		for (int i = 0; i < 5; i++) begin
			u_port_agent.cyc(0, 1, 1, 0, 0, 0, '0);
			`CHK(q, ofs[i])
		end
		last = ofs[4];
		$display("offset load test done");
		run(5, 3);
		// strap high: second enable, offsets locked at default
		rst(1'b1);
		u_port_agent.cyc(1, 0, 0, 0, 1, 1, 9'h001);
		idle3();
		`CHK(fl.empty_n, 1'b0)
		$display("second enable block test done");
		run(7, 7);
		report_and_stop();
	end
endmodule
